// File: design/psc_pkg.sv
// Constants, object indices and types for the pulse command scaling block
package psc_pkg;
  // Object dictionary indices
  localparam logic [15:0] IDX_DESIRED_STATE = 16'h2300;
  localparam logic [15:0] IDX_IN_CFG        = 16'h2320;
  localparam logic [15:0] IDX_SCALE         = 16'h2321;
  localparam logic [15:0] IDX_TRAJ_OPT      = 16'h2255;
  localparam logic [15:0] IDX_REG_OFS       = 16'h2325;
  localparam logic [15:0] IDX_PIN_STATES    = 16'h2190;
  localparam logic [15:0] IDX_INTERP_TIME   = 16'h60c2;
  localparam logic [15:0] IDX_IN_STATUS     = 16'h2f00;
  // Desired state codes; all but DS_CSP use the digital control inputs
  localparam logic [15:0] DS_PWM_CURRENT    = 16'h0002;
  localparam logic [15:0] DS_PWM_VELOCITY   = 16'h000c;
  localparam logic [15:0] DS_CSP            = 16'h000b;
  localparam logic [15:0] DS_PULSE_POS      = 16'h0017;
  // Trajectory option fields
  localparam int          OPT_EXTRAP_LSB    = 0;
  localparam int          OPT_EXTRAP_W      = 8;
  localparam int          OPT_QSTOP_BIT     = 16;
  localparam int          OPT_VFILT_BIT     = 17;
  // Input configuration fields
  localparam int          CFG_PIN_MODE_LSB  = 8;
  localparam int          CFG_FALL_BIT      = 12;
  localparam int          CFG_INV_BIT       = 13;
  localparam logic [1:0]  PIN_STEP_DIR      = 2'h0;
  localparam logic [1:0]  PIN_UP_DOWN       = 2'h1;
  localparam logic [1:0]  PIN_QUADRATURE    = 2'h2;
  // Input status word fields
  localparam int          STAT_NEG_LIM      = 0;
  localparam int          STAT_POS_LIM      = 1;
  localparam int          STAT_HOME         = 2;
  localparam int          STAT_ENABLE       = 3;
  localparam int          STAT_RAW_LSB      = 16;
  // Scaling and filter
  localparam int          PWM_FRAC          = 15;
  localparam int          VFILT_SHIFT       = 2;
  localparam logic [31:0] RST_WORD          = 32'h0000_0000;
  localparam logic [15:0] RST_HALF          = 16'h0000;

  typedef enum logic [1:0] {
    CSP_IDLE   = 2'b00,
    CSP_TRACK  = 2'b01,
    CSP_EXTRAP = 2'b10,
    CSP_QSTOP  = 2'b11
  } psc_csp_state_t;
endpackage

// File: design/psc_pulse_decoder.sv
// Position input pin decoder: step/direction, up/down, quadrature
`timescale 1ns/1ps
module psc_pulse_decoder (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic       pin_a,
  input  wire logic       pin_b,
  input  wire logic [1:0] pin_mode,
  input  wire logic       count_fall,
  input  wire logic       invert,
  output logic            step_valid,
  output logic            step_neg
);
  logic a_reg;
  logic b_reg;
  logic edge_a;
  logic edge_b;
  logic v_next;
  logic n_next;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      a_reg <= 1'b0;
      b_reg <= 1'b0;
    end else begin
      a_reg <= pin_a;
      b_reg <= pin_b;
    end
  end

  assign edge_a = count_fall ? (a_reg & ~pin_a) : (~a_reg & pin_a);
  assign edge_b = count_fall ? (b_reg & ~pin_b) : (~b_reg & pin_b);

  always_comb begin
    case (pin_mode)
      psc_pkg::PIN_STEP_DIR: begin
        v_next = edge_a;
        n_next = pin_b;
      end
      psc_pkg::PIN_UP_DOWN: begin
        v_next = edge_a ^ edge_b;
        n_next = edge_b;
      end
      psc_pkg::PIN_QUADRATURE: begin
        v_next = (pin_a ^ a_reg) ^ (pin_b ^ b_reg);
        n_next = a_reg ^ pin_b;
      end
      default: begin
        v_next = 1'b0;
        n_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      step_valid <= 1'b0;
      step_neg   <= 1'b0;
    end else begin
      step_valid <= v_next;
      step_neg   <= n_next ^ invert;
    end
  end

  a_step_dir_edge: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (pin_mode == psc_pkg::PIN_STEP_DIR && !count_fall && !a_reg && pin_a)
    |=> (step_valid && step_neg == $past(pin_b ^ invert)))
    else $error("step edge not decoded");
endmodule // psc_pulse_decoder

// File: design/psc_ratio_scaler.sv
// Ratio scaler: numerator/denominator units per pulse, remainder carried
`timescale 1ns/1ps
module psc_ratio_scaler #(
  parameter int ACC_W = 34
) (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic        pulse_valid,
  input  wire logic        pulse_neg,
  input  wire logic [15:0] ratio_num,
  input  wire logic [15:0] ratio_den,
  output logic             unit_valid,
  output logic             unit_neg
);
  if (ACC_W < 18) begin : g_chk
    $error("ACC_W too small for ratio remainder");
  end

  logic signed [ACC_W-1:0] rem_reg;
  logic signed [ACC_W-1:0] num_ext;
  logic signed [ACC_W-1:0] den_ext;
  logic signed [ACC_W-1:0] add_v;
  logic signed [ACC_W-1:0] sub_v;
  logic                    emit_pos;
  logic                    emit_neg;

  assign num_ext  = ACC_W'($unsigned(ratio_num));
  assign den_ext  = ACC_W'($unsigned(ratio_den));
  assign emit_pos = (ratio_den != 16'h0000) && (rem_reg >= den_ext);
  assign emit_neg = (ratio_den != 16'h0000) && (rem_reg <= -den_ext);
  assign add_v    = (pulse_valid && ratio_den != 16'h0000)
                    ? (pulse_neg ? -num_ext : num_ext) : '0;
  assign sub_v    = emit_pos ? den_ext : (emit_neg ? -den_ext : '0);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      rem_reg <= '0;
    end else begin
      rem_reg <= rem_reg + add_v - sub_v;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      unit_valid <= 1'b0;
      unit_neg   <= 1'b0;
    end else begin
      unit_valid <= emit_pos | emit_neg;
      unit_neg   <= emit_neg;
    end
  end

  a_ratio_unit: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (emit_pos && !pulse_valid)
    |=> (unit_valid && !unit_neg && rem_reg == $past(rem_reg) - $past(den_ext)))
    else $error("unit step not taken from remainder");
  a_rem_kept: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!pulse_valid && !emit_pos && !emit_neg) |=> (rem_reg == $past(rem_reg)))
    else $error("remainder lost");
  c_unit_step: cover property (@(posedge sys_clk) disable iff (!reset_n)
    pulse_valid ##1 unit_valid);
endmodule // psc_ratio_scaler

// File: design/psc_top.sv
// Digital command input scaling, input status and trajectory options
//
// Functional notes
// - Current mode scale is full-PWM current, 0.01 A.
// - Velocity mode scale is full-PWM velocity, 0.1 counts/s.
// - Position scale: high word numerator, low denominator.
// - Each pulse moves numerator/denominator encoder units.
// - Scaling only in digital-input desired states.
// - Status bit0 negative limit, bit1 positive limit.
// - Status bit2 home, bit3 enable input.
// - Raw pins in upper half; bits 4-15 zero.
// - CSP extrapolates up to option bits 0-7 cycles.
// - Option bit16 enters quick stop after limit.
// - Option bit17 with interpolation time filters velocity.
// - State 23 adds registration offset to master position.
// - Registration offset clears right after being applied.
// - Pin mode: step/dir, up/down, quadrature.
`timescale 1ns/1ps
module psc_top (
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] od_index,
  input  wire logic        od_wr,
  input  wire logic        od_rd,
  input  wire logic [31:0] od_wdata,
  output logic      [31:0] od_rdata,
  output logic             od_ack,
  output logic             od_err,
  input  wire logic        neg_lim_in,
  input  wire logic        pos_lim_in,
  input  wire logic        home_in,
  input  wire logic        amp_en_in,
  input  wire logic [15:0] pin_raw,
  input  wire logic        pulse_a,
  input  wire logic        pulse_b,
  input  wire logic [15:0] pwm_duty,
  input  wire logic        loop_tick,
  input  wire logic        master_valid,
  input  wire logic [31:0] master_pos_in,
  output logic      [31:0] current_cmd,
  output logic      [31:0] velocity_cmd,
  output logic      [31:0] master_pos,
  output logic      [31:0] traj_pos,
  output logic      [31:0] traj_vel,
  output logic      [31:0] traj_acc,
  output logic             quick_stop,
  output logic             extrapolating
);
  logic                  [15:0] ds_reg;
  logic                  [15:0] cfg_reg;
  logic                  [31:0] scale_reg;
  logic                  [31:0] opt_reg;
  logic                  [31:0] ofs_reg;
  logic                  [31:0] interp_reg;
  logic                  [31:0] status_word;
  logic                  [31:0] od_rdata_next;
  logic                         mapped;
  logic                         step_valid;
  logic                         step_neg;
  logic                         unit_valid;
  logic                         unit_neg;
  logic                         pulse_mode;
  logic                         ofs_apply;
  logic                         ofs_wr;
  logic signed           [31:0] step_delta;
  logic signed           [47:0] pwm_prod;
  logic signed           [31:0] vel_raw;
  logic signed           [31:0] vel_diff;
  logic signed           [31:0] vel_filt;
  logic                         filt_on;
  logic                         csp_on;
  logic                         take_data;
  logic                         extrap_step;
  logic                         qstop_hit;
  logic                   [7:0] missing_reg;
  logic                   [7:0] extrap_lim;
  psc_pkg::psc_csp_state_t      csp_state_reg;

  // Input status word
  always_comb begin
    status_word                                 = psc_pkg::RST_WORD;
    status_word[psc_pkg::STAT_NEG_LIM]          = neg_lim_in;
    status_word[psc_pkg::STAT_POS_LIM]          = pos_lim_in;
    status_word[psc_pkg::STAT_HOME]             = home_in;
    status_word[psc_pkg::STAT_ENABLE]           = amp_en_in;
    status_word[psc_pkg::STAT_RAW_LSB +: 16]    = pin_raw;
  end

  // Object writes
  assign ofs_wr = od_wr && od_index == psc_pkg::IDX_REG_OFS;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ds_reg     <= psc_pkg::RST_HALF;
      cfg_reg    <= psc_pkg::RST_HALF;
      scale_reg  <= psc_pkg::RST_WORD;
      opt_reg    <= psc_pkg::RST_WORD;
      interp_reg <= psc_pkg::RST_WORD;
    end else if (od_wr) begin
      if (od_index == psc_pkg::IDX_DESIRED_STATE) begin
        ds_reg <= od_wdata[15:0];
      end else if (od_index == psc_pkg::IDX_IN_CFG) begin
        cfg_reg <= od_wdata[15:0];
      end else if (od_index == psc_pkg::IDX_SCALE) begin
        scale_reg <= od_wdata;
      end else if (od_index == psc_pkg::IDX_TRAJ_OPT) begin
        opt_reg <= od_wdata;
      end else if (od_index == psc_pkg::IDX_INTERP_TIME) begin
        interp_reg <= od_wdata;
      end
    end
  end

  // Registration offset: a write wins over the clear
  assign pulse_mode = ds_reg == psc_pkg::DS_PULSE_POS;
  assign ofs_apply  = pulse_mode && ofs_reg != psc_pkg::RST_WORD;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      ofs_reg <= psc_pkg::RST_WORD;
    end else if (ofs_wr) begin
      ofs_reg <= od_wdata;
    end else if (ofs_apply) begin
      ofs_reg <= psc_pkg::RST_WORD;
    end
  end

  // Object reads
  always_comb begin
    mapped = 1'b1;
    if (od_index == psc_pkg::IDX_DESIRED_STATE) begin
      od_rdata_next = {16'h0000, ds_reg};
    end else if (od_index == psc_pkg::IDX_IN_CFG) begin
      od_rdata_next = {16'h0000, cfg_reg};
    end else if (od_index == psc_pkg::IDX_SCALE) begin
      od_rdata_next = scale_reg;
    end else if (od_index == psc_pkg::IDX_TRAJ_OPT) begin
      od_rdata_next = opt_reg;
    end else if (od_index == psc_pkg::IDX_REG_OFS) begin
      od_rdata_next = ofs_reg;
    end else if (od_index == psc_pkg::IDX_INTERP_TIME) begin
      od_rdata_next = interp_reg;
    end else if (od_index == psc_pkg::IDX_PIN_STATES) begin
      od_rdata_next = {16'h0000, pin_raw};
    end else if (od_index == psc_pkg::IDX_IN_STATUS) begin
      od_rdata_next = status_word;
    end else begin
      mapped        = 1'b0;
      od_rdata_next = psc_pkg::RST_WORD;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      od_rdata <= psc_pkg::RST_WORD;
      od_ack   <= 1'b0;
      od_err   <= 1'b0;
    end else begin
      od_rdata <= od_rd ? od_rdata_next : od_rdata;
      od_ack   <= od_rd | od_wr;
      od_err   <= (od_rd | od_wr) & ~mapped;
    end
  end

  // Pulse input path
  psc_pulse_decoder u_dec (
    .sys_clk    (sys_clk),
    .reset_n    (reset_n),
    .pin_a      (pulse_a),
    .pin_b      (pulse_b),
    .pin_mode   (cfg_reg[psc_pkg::CFG_PIN_MODE_LSB +: 2]),
    .count_fall (cfg_reg[psc_pkg::CFG_FALL_BIT]),
    .invert     (cfg_reg[psc_pkg::CFG_INV_BIT]),
    .step_valid (step_valid),
    .step_neg   (step_neg)
  );

  psc_ratio_scaler #(.ACC_W(34)) u_ratio (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .pulse_valid (step_valid && pulse_mode),
    .pulse_neg   (step_neg),
    .ratio_num   (scale_reg[31:16]),
    .ratio_den   (scale_reg[15:0]),
    .unit_valid  (unit_valid),
    .unit_neg    (unit_neg)
  );

  assign step_delta = unit_valid ? (unit_neg ? -32'sd1 : 32'sd1) : 32'sd0;

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      master_pos <= psc_pkg::RST_WORD;
    end else if (pulse_mode) begin
      master_pos <= master_pos + step_delta + (ofs_apply ? ofs_reg : 32'h0);
    end
  end

  // PWM current and velocity commands
  assign pwm_prod = $signed(pwm_duty) * $signed(scale_reg);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      current_cmd  <= psc_pkg::RST_WORD;
      velocity_cmd <= psc_pkg::RST_WORD;
    end else begin
      current_cmd  <= (ds_reg == psc_pkg::DS_PWM_CURRENT)
                      ? pwm_prod[psc_pkg::PWM_FRAC +: 32] : psc_pkg::RST_WORD;
      velocity_cmd <= (ds_reg == psc_pkg::DS_PWM_VELOCITY)
                      ? pwm_prod[psc_pkg::PWM_FRAC +: 32] : psc_pkg::RST_WORD;
    end
  end

  // Cyclic position: extrapolation and quick stop
  assign csp_on      = ds_reg == psc_pkg::DS_CSP;
  assign extrap_lim  = opt_reg[psc_pkg::OPT_EXTRAP_LSB +: psc_pkg::OPT_EXTRAP_W];
  assign take_data   = csp_on && loop_tick && master_valid
                       && csp_state_reg != psc_pkg::CSP_QSTOP;
  assign extrap_step = csp_on && loop_tick && !master_valid
                       && csp_state_reg != psc_pkg::CSP_QSTOP
                       && missing_reg < extrap_lim;
  assign qstop_hit   = csp_on && loop_tick && !master_valid
                       && missing_reg >= extrap_lim
                       && opt_reg[psc_pkg::OPT_QSTOP_BIT];

  always_ff @(posedge sys_clk) begin
    if (!reset_n || !csp_on) begin
      csp_state_reg <= psc_pkg::CSP_IDLE;
      missing_reg   <= 8'h00;
    end else begin
      case (csp_state_reg)
        psc_pkg::CSP_QSTOP: begin
          csp_state_reg <= psc_pkg::CSP_QSTOP;
        end
        default: begin
          if (take_data) begin
            csp_state_reg <= psc_pkg::CSP_TRACK;
            missing_reg   <= 8'h00;
          end else if (extrap_step) begin
            csp_state_reg <= psc_pkg::CSP_EXTRAP;
            missing_reg   <= missing_reg + 8'h01;
          end else if (qstop_hit) begin
            csp_state_reg <= psc_pkg::CSP_QSTOP;
          end
        end
      endcase
    end
  end

  assign quick_stop    = csp_state_reg == psc_pkg::CSP_QSTOP;
  assign extrapolating = csp_state_reg == psc_pkg::CSP_EXTRAP;

  assign filt_on  = opt_reg[psc_pkg::OPT_VFILT_BIT] && interp_reg != psc_pkg::RST_WORD;
  assign vel_raw  = master_pos_in - traj_pos;
  assign vel_diff = vel_raw - traj_vel;
  assign vel_filt = $signed(traj_vel) + (vel_diff >>> psc_pkg::VFILT_SHIFT);

  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      traj_pos <= psc_pkg::RST_WORD;
      traj_vel <= psc_pkg::RST_WORD;
      traj_acc <= psc_pkg::RST_WORD;
    end else if (take_data) begin
      traj_pos <= master_pos_in;
      traj_vel <= filt_on ? vel_filt : vel_raw;
      traj_acc <= filt_on ? vel_filt - traj_vel : psc_pkg::RST_WORD;
    end else if (extrap_step) begin
      traj_pos <= traj_pos + traj_vel;
    end
  end

  a_status_limits: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (od_rd && od_index == psc_pkg::IDX_IN_STATUS)
    |=> od_rdata[1:0] == $past({pos_lim_in, neg_lim_in}))
    else $error("limit bits wrong in status");
  a_status_home_en: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (od_rd && od_index == psc_pkg::IDX_IN_STATUS)
    |=> od_rdata[3:2] == $past({amp_en_in, home_in}))
    else $error("home or enable bit wrong in status");
  a_status_raw: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (od_rd && od_index == psc_pkg::IDX_IN_STATUS)
    |=> (od_rdata[31:16] == $past(pin_raw) && od_rdata[15:4] == 12'h000))
    else $error("raw pins or reserved bits wrong");
  a_cur_full_scale: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ds_reg == psc_pkg::DS_PWM_CURRENT && pwm_duty == 16'h8000 && $stable(scale_reg))
    |=> current_cmd == -$past(scale_reg))
    else $error("current command not scaled");
  a_vel_full_scale: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ds_reg == psc_pkg::DS_PWM_VELOCITY && pwm_duty == 16'h8000 && $stable(scale_reg))
    |=> velocity_cmd == -$past(scale_reg))
    else $error("velocity command not scaled");
  a_mode_gate: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ds_reg != psc_pkg::DS_PWM_CURRENT && ds_reg != psc_pkg::DS_PWM_VELOCITY)
    |=> (current_cmd == 32'h0 && velocity_cmd == 32'h0))
    else $error("command outside digital input mode");
  a_extrap_bound: assert property (@(posedge sys_clk) disable iff (!reset_n)
    extrapolating |-> (missing_reg <= extrap_lim && missing_reg != 8'h00))
    else $error("extrapolation past limit");
  a_qstop_entry: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (qstop_hit && !quick_stop) |=> quick_stop ##1 (quick_stop || !csp_on))
    else $error("quick stop not entered");
  a_vfilt_off: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (take_data && !filt_on) |=> (traj_acc == 32'h0 && traj_vel == $past(vel_raw)))
    else $error("unfiltered velocity wrong");
  a_ofs_inject: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ofs_apply && !unit_valid)
    |=> master_pos == $past(master_pos) + $past(ofs_reg))
    else $error("offset not added");
  a_ofs_clear: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (ofs_apply && !ofs_wr) |=> ofs_reg == 32'h0)
    else $error("offset not cleared");
  c_qstop: cover property (@(posedge sys_clk) disable iff (!reset_n)
    extrapolating ##[1:20] quick_stop);
  c_ofs_apply: cover property (@(posedge sys_clk) disable iff (!reset_n)
    ofs_wr ##1 ofs_apply ##1 ofs_reg == 32'h0);
  c_filtered: cover property (@(posedge sys_clk) disable iff (!reset_n)
    take_data && filt_on);
endmodule // psc_top

// File: verif/psc_ctl_model.sv
// Motion controller model driving the position input pins
`timescale 1ns/1ps
module psc_ctl_model (
  input  wire logic       sys_clk,
  input  wire logic [1:0] mode,
  input  wire logic       start,
  input  wire logic [7:0] count,
  output logic            pulse_a,
  output logic            pulse_b,
  output logic            busy
);
  logic [7:0] left_reg = 8'h00;
  logic [1:0] ph_reg   = 2'h0;
  logic [1:0] gray_reg = 2'h0;
  // One count every four cycles
  always_ff @(posedge sys_clk) begin
    if (start) begin
      left_reg <= count;
      ph_reg   <= 2'h0;
    end else if (left_reg != 8'h00) begin
      ph_reg <= ph_reg + 2'h1;
      if (ph_reg == 2'h3) begin
        left_reg <= left_reg - 8'h01;
        gray_reg <= {gray_reg[0], ~gray_reg[1]};
      end
    end
  end
  assign busy    = (left_reg != 8'h00);
  // Step pulse high two cycles of four, or quadrature gray code
  assign pulse_a = (mode == 2'h2) ? gray_reg[1] : (busy && !ph_reg[1]);
  assign pulse_b = (mode == 2'h2) ? gray_reg[0] : 1'b0;
endmodule // psc_ctl_model

// File: verif/psc_top_tb.sv
// Self-checking testbench for the pulse command scaling block
`timescale 1ns/1ps
module psc_top_tb;
  logic        sys_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [15:0] od_index = 16'h0000;
  logic        od_wr = 1'b0;
  logic        od_rd = 1'b0;
  logic [31:0] od_wdata = 32'h0;
  logic [31:0] od_rdata;
  logic        od_ack;
  logic        od_err;
  logic        neg_lim_in = 1'b0;
  logic        pos_lim_in = 1'b0;
  logic        home_in = 1'b0;
  logic        amp_en_in = 1'b0;
  logic [15:0] pin_raw = 16'h0000;
  logic        pulse_a;
  logic        pulse_b;
  logic [15:0] pwm_duty = 16'h0000;
  logic        loop_tick = 1'b0;
  logic        master_valid = 1'b0;
  logic [31:0] master_pos_in = 32'h0;
  logic [31:0] current_cmd;
  logic [31:0] velocity_cmd;
  logic [31:0] master_pos;
  logic [31:0] traj_pos;
  logic [31:0] traj_vel;
  logic [31:0] traj_acc;
  logic        quick_stop;
  logic        extrapolating;
  logic [1:0]  gen_mode = 2'h0;
  logic        gen_start = 1'b0;
  logic [7:0]  gen_count = 8'h00;
  logic        gen_busy;
  logic [31:0] pos0;
  logic [31:0] diff;
  int          err_total = 0;
  int          num_checks = 0;

  initial forever #20 sys_clk = ~sys_clk;

  psc_top uut (.sys_clk(sys_clk), .reset_n(reset_n), .od_index(od_index), .od_wr(od_wr),
    .od_rd(od_rd), .od_wdata(od_wdata), .od_rdata(od_rdata), .od_ack(od_ack),
    .od_err(od_err), .neg_lim_in(neg_lim_in), .pos_lim_in(pos_lim_in), .home_in(home_in),
    .amp_en_in(amp_en_in), .pin_raw(pin_raw), .pulse_a(pulse_a), .pulse_b(pulse_b),
    .pwm_duty(pwm_duty), .loop_tick(loop_tick), .master_valid(master_valid),
    .master_pos_in(master_pos_in), .current_cmd(current_cmd), .velocity_cmd(velocity_cmd),
    .master_pos(master_pos), .traj_pos(traj_pos), .traj_vel(traj_vel), .traj_acc(traj_acc),
    .quick_stop(quick_stop), .extrapolating(extrapolating));

  psc_ctl_model ctl (.sys_clk(sys_clk), .mode(gen_mode), .start(gen_start),
    .count(gen_count), .pulse_a(pulse_a), .pulse_b(pulse_b), .busy(gen_busy));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One object access; ack and data looked at in the answer cycle
  task automatic od_acc(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                        input logic err_exp, output logic [31:0] rd);
    @(posedge sys_clk);
    od_wr    <= wr;
    od_rd    <= !wr;
    od_index <= idx;
    od_wdata <= d;
    @(posedge sys_clk);
    od_wr <= 1'b0;
    od_rd <= 1'b0;
    @(negedge sys_clk);
    chk({30'h0, od_ack, od_err}, {30'h0, 1'b1, err_exp});
    rd = od_rdata;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    od_acc(1'b1, idx, d, 1'b0, rd);
  endtask

  task automatic rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    od_acc(1'b0, idx, 32'h0, 1'b0, rd);
    chk(rd, exp);
  endtask

  // Sends n counts and returns the magnitude of the position change
  task automatic pulses(input logic [1:0] m, input logic [7:0] n);
    pos0 = master_pos;
    gen_mode  <= m;
    @(posedge sys_clk);
    gen_count <= n;
    gen_start <= 1'b1;
    @(posedge sys_clk);
    gen_start <= 1'b0;
    repeat (8) @(posedge sys_clk);
    for (int i = 0; i < 2000 && gen_busy; i++) @(posedge sys_clk);
    repeat (8) @(posedge sys_clk);
    diff = master_pos - pos0;
    if (diff[31]) diff = -diff;
  endtask

  task automatic tick(input logic v, input logic [31:0] p);
    @(posedge sys_clk);
    loop_tick     <= 1'b1;
    master_valid  <= v;
    master_pos_in <= p;
    @(posedge sys_clk);
    loop_tick <= 1'b0;
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask

  task automatic tally_and_finish;
    if (err_total == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial begin
    logic [31:0] rd;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    neg_lim_in <= 1'b1;
    home_in    <= 1'b1;
    pin_raw    <= 16'ha5c3;
    rd_chk(psc_pkg::IDX_IN_STATUS, 32'ha5c3_0005);
    neg_lim_in <= 1'b0;
    home_in    <= 1'b0;
    pos_lim_in <= 1'b1;
    amp_en_in  <= 1'b1;
    rd_chk(psc_pkg::IDX_IN_STATUS, 32'ha5c3_000a);
    od_acc(1'b0, 16'h1234, 32'h0, 1'b1, rd);
    wr(psc_pkg::IDX_IN_STATUS, 32'hffff_ffff);
    rd_chk(psc_pkg::IDX_IN_STATUS, 32'ha5c3_000a);
    pwm_duty <= 16'h4000;
    wr(psc_pkg::IDX_SCALE, 32'h0000_0064);
    wr(psc_pkg::IDX_DESIRED_STATE, {16'h0, psc_pkg::DS_PWM_CURRENT});
    repeat (3) @(posedge sys_clk);
    chk(current_cmd, 32'h0000_0032);
    pwm_duty <= 16'h8000;
    repeat (3) @(posedge sys_clk);
    chk(current_cmd, 32'hffff_ff9c);
    pwm_duty <= 16'hc000;
    wr(psc_pkg::IDX_SCALE, 32'h0000_03e8);
    wr(psc_pkg::IDX_DESIRED_STATE, {16'h0, psc_pkg::DS_PWM_VELOCITY});
    repeat (3) @(posedge sys_clk);
    chk(velocity_cmd, 32'hffff_fe0c);
    pwm_duty <= 16'h8000;
    repeat (3) @(posedge sys_clk);
    chk(velocity_cmd, 32'hffff_fc18);
    chk(current_cmd, 32'h0);
    wr(psc_pkg::IDX_DESIRED_STATE, 32'h0000_0001);
    repeat (3) @(posedge sys_clk);
    chk(velocity_cmd, 32'h0);
    wr(psc_pkg::IDX_DESIRED_STATE, {16'h0, psc_pkg::DS_PULSE_POS});
    wr(psc_pkg::IDX_IN_CFG, 32'h0);
    wr(psc_pkg::IDX_SCALE, 32'h0001_0003);
    pulses(2'h0, 8'd7);
    chk(diff, 32'd2);
    pulses(2'h0, 8'd2);
    chk(diff, 32'd1);
    wr(psc_pkg::IDX_SCALE, 32'h0002_0001);
    pulses(2'h0, 8'd3);
    chk(diff, 32'd6);
    wr(psc_pkg::IDX_SCALE, 32'h0001_0001);
    wr(psc_pkg::IDX_IN_CFG, 32'h0000_3100);
    pulses(2'h1, 8'd4);
    chk(diff, 32'd4);
    chk(master_pos - pos0, 32'hffff_fffc);
    wr(psc_pkg::IDX_IN_CFG, 32'h0000_0200);
    pulses(2'h2, 8'd4);
    chk(diff, 32'd4);
    pos0 = master_pos;
    wr(psc_pkg::IDX_REG_OFS, 32'h0000_0010);
    @(negedge sys_clk);
    chk(master_pos - pos0, 32'h0000_0010);
    rd_chk(psc_pkg::IDX_REG_OFS, 32'h0);
    wr(psc_pkg::IDX_TRAJ_OPT, 32'h0001_0002);
    wr(psc_pkg::IDX_DESIRED_STATE, {16'h0, psc_pkg::DS_CSP});
    tick(1'b1, 32'h0000_0100);
    chk(traj_pos, 32'h0000_0100);
    tick(1'b1, 32'h0000_0110);
    tick(1'b0, 32'h0);
    chk({31'h0, extrapolating}, 32'h1);
    chk(traj_pos, 32'h0000_0120);
    chk(traj_acc, 32'h0);
    tick(1'b0, 32'h0);
    chk({31'h0, quick_stop}, 32'h0);
    tick(1'b0, 32'h0);
    chk({31'h0, quick_stop}, 32'h1);
    wr(psc_pkg::IDX_DESIRED_STATE, 32'h0000_0001);
    wr(psc_pkg::IDX_TRAJ_OPT, 32'h0002_0000);
    wr(psc_pkg::IDX_INTERP_TIME, 32'h0000_0001);
    wr(psc_pkg::IDX_DESIRED_STATE, {16'h0, psc_pkg::DS_CSP});
    tick(1'b1, 32'h0000_0180);
    chk(traj_vel, 32'h0000_0020);
    chk(traj_acc, 32'h0000_0010);
    tick(1'b1, 32'h0000_0180);
    chk(traj_vel, 32'h0000_0018);
    chk(traj_acc, 32'hffff_fff8);
    tally_and_finish();
  end

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    tally_and_finish();
  end
endmodule // psc_top_tb
